// file: dll_core.sv
// data link layer core: sequence, lcrc, replay, ack/nak, arbitration, link control
`timescale 1ns/1ps
`default_nettype none
module dll_core (
   input wire logic clk,
   input wire logic rst,
   // transaction layer transmit (one word per tlp)
   input wire logic tl_tx_valid,
   input wire logic [dll_pkg::DATA_W-1:0] tl_tx_data,
   output logic tl_tx_ready,
   // transaction layer receive
   output logic tl_rx_valid,
   output logic [dll_pkg::DATA_W-1:0] tl_rx_data,
   // flow credits
   input wire dll_pkg::credit_s tl_credit_adv,
   input wire logic tl_credit_upd,
   output dll_pkg::credit_s tl_credit_peer,
   output logic tl_link_up,
   // physical layer transmit
   output logic ph_tx_valid,
   output logic ph_tx_is_dllp,
   output dll_pkg::tlp_s ph_tx_tlp,
   output logic [31:0] ph_tx_crc,
   output dll_pkg::dllp_s ph_tx_dllp,
   input wire logic ph_tx_ready,
   // physical layer receive
   input wire logic ph_rx_tlp_valid,
   input wire dll_pkg::tlp_s ph_rx_tlp,
   input wire logic [31:0] ph_rx_tlp_crc,
   input wire logic ph_rx_dllp_valid,
   input wire dll_pkg::dllp_s ph_rx_dllp,
   input wire logic [15:0] ph_rx_dllp_crc,
   // physical layer training
   input wire logic ph_link_trained,
   output logic ph_retrain,
   output logic pm_low_power_req
);
   typedef enum logic [1:0] {LS_DOWN, LS_INIT, LS_UP} link_e;

   function automatic logic [31:0] lcrc(input logic [43:0] d);
      logic [31:0] c;
      c = dll_pkg::LCRC_INIT;
      for (int b = 43; b >= 0; b--) begin
         c = {c[30:0], 1'b0} ^ ((c[31] ^ d[b]) ? dll_pkg::LCRC_POLY : 32'h00000000);
      end
      return ~c;
   endfunction : lcrc

   function automatic logic [15:0] dcrc(input logic [31:0] d);
      logic [15:0] c;
      c = dll_pkg::DLLP_INIT;
      for (int b = 31; b >= 0; b--) begin
         c = {c[14:0], 1'b0} ^ ((c[15] ^ d[b]) ? dll_pkg::DLLP_POLY : 16'h0000);
      end
      return ~c;
   endfunction : dcrc

   link_e link_q;
   logic [dll_pkg::DATA_W-1:0] rb_mem [dll_pkg::RB_DEPTH];
   logic [11:0] next_seq_q, acked_seq_q, replay_seq_q, rx_seq_q, tmr_q;
   logic replay_q, ack_pend_q, nak_pend_q, nak_sched_q, ufc_pend_q, init_done_q;
   logic [3:0] err_cnt_q;
   logic [11:0] in_flight;
   logic rb_full, ack_ok, nak_ok, rx_crc_ok, rx_dllp_ok, fire, err_ev;
   logic [dll_pkg::NREQ-1:0] req, gnt;
   dll_pkg::tlp_s tx_tlp;

   assign in_flight = next_seq_q - acked_seq_q - 12'h001;
   assign rb_full = in_flight >= 12'(dll_pkg::RB_DEPTH - 1);
   assign rx_dllp_ok = ph_rx_dllp_valid && (dcrc(ph_rx_dllp) == ph_rx_dllp_crc);
   assign ack_ok = rx_dllp_ok && ph_rx_dllp.dtype == dll_pkg::DT_ACK;
   assign nak_ok = rx_dllp_ok && ph_rx_dllp.dtype == dll_pkg::DT_NAK;
   assign rx_crc_ok = lcrc(ph_rx_tlp) == ph_rx_tlp_crc;
   assign err_ev = (ph_rx_tlp_valid && !rx_crc_ok) || (ph_rx_dllp_valid && !rx_dllp_ok);

   // request vector, index order is the grant order
   always_comb begin
      req = '0;
      req[dll_pkg::SRC_INITFC] = link_q == LS_INIT && !init_done_q;
      req[dll_pkg::SRC_ACK_HI] = link_q == LS_UP && nak_pend_q;
      req[dll_pkg::SRC_UFC_HI] = link_q == LS_UP && ufc_pend_q && tl_credit_upd;
      req[dll_pkg::SRC_PM] = 1'b0;
      req[dll_pkg::SRC_REPLAY] = link_q == LS_UP && replay_q;
      req[dll_pkg::SRC_NEW] = link_q == LS_UP && !replay_q && tl_tx_valid && !rb_full;
      req[dll_pkg::SRC_UFC_LO] = link_q == LS_UP && ufc_pend_q && !tl_credit_upd;
      req[dll_pkg::SRC_ACK_LO] = link_q == LS_UP && ack_pend_q;
   end

   dll_arbiter u_arb (
      .req(req),
      .gnt(gnt)
   );

   assign fire = ph_tx_ready || !ph_tx_valid;
   assign tx_tlp.seq = gnt[dll_pkg::SRC_REPLAY] ? replay_seq_q : next_seq_q;
   assign tx_tlp.data = gnt[dll_pkg::SRC_REPLAY] ? rb_mem[replay_seq_q[dll_pkg::RB_AW-1:0]] : tl_tx_data;
   assign tl_tx_ready = fire && gnt[dll_pkg::SRC_NEW];

   // transmit output stage
   always_ff @(posedge clk) begin
      if (rst) begin
         ph_tx_valid <= 1'b0;
         ph_tx_is_dllp <= 1'b0;
         ph_tx_tlp <= '0;
         ph_tx_crc <= '0;
         ph_tx_dllp <= '0;
      end else if (fire) begin
         ph_tx_valid <= |req;
         ph_tx_is_dllp <= !(gnt[dll_pkg::SRC_REPLAY] || gnt[dll_pkg::SRC_NEW]);
         ph_tx_tlp <= tx_tlp;
         if (gnt[dll_pkg::SRC_REPLAY] || gnt[dll_pkg::SRC_NEW]) begin
            ph_tx_crc <= lcrc(tx_tlp);
         end else begin
            ph_tx_dllp.dtype <= (gnt[dll_pkg::SRC_INITFC]) ? dll_pkg::DT_INITFC :
               (gnt[dll_pkg::SRC_UFC_HI] || gnt[dll_pkg::SRC_UFC_LO]) ? dll_pkg::DT_UPDFC :
               nak_pend_q ? dll_pkg::DT_NAK : dll_pkg::DT_ACK;
            ph_tx_dllp.body <= (gnt[dll_pkg::SRC_ACK_HI] || gnt[dll_pkg::SRC_ACK_LO]) ?
               {12'h000, rx_seq_q - 12'h001} : {tl_credit_adv.hdr, 4'h0, tl_credit_adv.data};
            ph_tx_crc <= {16'h0000, dcrc(ph_tx_dllp_next(gnt))};
         end
      end
   end

   function automatic logic [31:0] ph_tx_dllp_next(input logic [dll_pkg::NREQ-1:0] g);
      logic [7:0] t;
      t = g[dll_pkg::SRC_INITFC] ? dll_pkg::DT_INITFC :
         (g[dll_pkg::SRC_UFC_HI] || g[dll_pkg::SRC_UFC_LO]) ? dll_pkg::DT_UPDFC :
         nak_pend_q ? dll_pkg::DT_NAK : dll_pkg::DT_ACK;
      if (g[dll_pkg::SRC_ACK_HI] || g[dll_pkg::SRC_ACK_LO]) begin
         return {t, 12'h000, rx_seq_q - 12'h001};
      end
      return {t, tl_credit_adv.hdr, 4'h0, tl_credit_adv.data};
   endfunction : ph_tx_dllp_next

   // replay buffer write on new tlp
   always_ff @(posedge clk) begin
      if (fire && gnt[dll_pkg::SRC_NEW]) begin
         rb_mem[next_seq_q[dll_pkg::RB_AW-1:0]] <= tl_tx_data;
      end
   end

   // sequence and ack tracking
   always_ff @(posedge clk) begin
      if (rst) begin
         next_seq_q <= dll_pkg::SEQ_RST;
         acked_seq_q <= dll_pkg::SEQ_RST - 12'h001;
      end else begin
         if (fire && gnt[dll_pkg::SRC_NEW]) begin
            next_seq_q <= next_seq_q + 12'h001;
         end
         // accept only acks and naks inside the outstanding window, older ones are stale
         if ((ack_ok || nak_ok) && (ph_rx_dllp.body[11:0] - acked_seq_q) <= in_flight &&
             ph_rx_dllp.body[11:0] != acked_seq_q) begin
            acked_seq_q <= ph_rx_dllp.body[11:0];
         end
      end
   end

   // replay control and timer
   always_ff @(posedge clk) begin
      if (rst) begin
         replay_q <= 1'b0;
         replay_seq_q <= dll_pkg::SEQ_RST;
         tmr_q <= '0;
      end else begin
         if (in_flight == 12'h000 || ack_ok) begin
            tmr_q <= '0;
         end else if (!replay_q) begin
            tmr_q <= tmr_q + 12'h001;
         end
         if (!replay_q && (nak_ok || tmr_q >= dll_pkg::REPLAY_CYC) && in_flight != 12'h000) begin
            replay_q <= 1'b1;
            replay_seq_q <= (nak_ok ? ph_rx_dllp.body[11:0] : acked_seq_q) + 12'h001;
            tmr_q <= '0;
         end else if (replay_q && fire && gnt[dll_pkg::SRC_REPLAY]) begin
            replay_seq_q <= replay_seq_q + 12'h001;
            if (replay_seq_q + 12'h001 == next_seq_q) begin
               replay_q <= 1'b0;
            end
         end
      end
   end

   // receive tlp check and ack/nak scheduling
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_seq_q <= dll_pkg::SEQ_RST;
         ack_pend_q <= 1'b0;
         nak_pend_q <= 1'b0;
         nak_sched_q <= 1'b0;
         tl_rx_valid <= 1'b0;
         tl_rx_data <= '0;
      end else begin
         tl_rx_valid <= 1'b0;
         if (fire && (gnt[dll_pkg::SRC_ACK_HI] || gnt[dll_pkg::SRC_ACK_LO])) begin
            ack_pend_q <= 1'b0;
            nak_pend_q <= 1'b0;
         end
         if (ph_rx_tlp_valid) begin
            if (rx_crc_ok && ph_rx_tlp.seq == rx_seq_q) begin
               rx_seq_q <= rx_seq_q + 12'h001;
               tl_rx_valid <= 1'b1;
               tl_rx_data <= ph_rx_tlp.data;
               ack_pend_q <= 1'b1;
               nak_sched_q <= 1'b0;
            end else if (rx_crc_ok && (rx_seq_q - ph_rx_tlp.seq) < dll_pkg::SEQ_HALF) begin
               ack_pend_q <= 1'b1; // duplicate, re-ack
            end else if (!nak_sched_q) begin
               nak_pend_q <= 1'b1;
               nak_sched_q <= 1'b1;
            end
         end
      end
   end

   // link control, credits, retrain, power
   always_ff @(posedge clk) begin
      if (rst) begin
         link_q <= LS_DOWN;
         init_done_q <= 1'b0;
         ufc_pend_q <= 1'b0;
         tl_link_up <= 1'b0;
         tl_credit_peer <= '0;
         err_cnt_q <= '0;
         ph_retrain <= 1'b0;
         pm_low_power_req <= 1'b0;
      end else begin
         ph_retrain <= 1'b0;
         if (fire && (gnt[dll_pkg::SRC_UFC_HI] || gnt[dll_pkg::SRC_UFC_LO])) begin
            ufc_pend_q <= 1'b0;
         end
         if (tl_credit_upd && link_q == LS_UP) begin
            ufc_pend_q <= 1'b1;
         end
         if (rx_dllp_ok && (ph_rx_dllp.dtype == dll_pkg::DT_INITFC || ph_rx_dllp.dtype == dll_pkg::DT_UPDFC)) begin
            tl_credit_peer <= {ph_rx_dllp.body[23:16], ph_rx_dllp.body[11:0]};
         end
         case (link_q)
            LS_DOWN: begin
               init_done_q <= 1'b0;
               if (ph_link_trained) begin
                  link_q <= LS_INIT;
               end
            end
            LS_INIT: begin
               if (fire && gnt[dll_pkg::SRC_INITFC]) begin
                  init_done_q <= 1'b1;
               end
               if (!ph_link_trained) begin
                  link_q <= LS_DOWN;
               end else if (init_done_q && rx_dllp_ok && ph_rx_dllp.dtype == dll_pkg::DT_INITFC) begin
                  link_q <= LS_UP;
               end
            end
            LS_UP: begin
               if (!ph_link_trained) begin
                  link_q <= LS_DOWN;
               end
            end
            default: link_q <= LS_DOWN;
         endcase
         tl_link_up <= link_q == LS_UP;
         if (err_ev) begin
            if (err_cnt_q == dll_pkg::ERR_RETRAIN - 4'h1) begin
               ph_retrain <= 1'b1;
               err_cnt_q <= '0;
            end else begin
               err_cnt_q <= err_cnt_q + 4'h1;
            end
         end
      end
   end

   chk_no_low_power: assert property (@(posedge clk) disable iff (rst)
      !pm_low_power_req && !req[dll_pkg::SRC_PM]) else $error("low power requested");
   chk_grant_onehot: assert property (@(posedge clk) disable iff (rst)
      $onehot0(gnt)) else $error("grant not one-hot");
   chk_ack_beats_new: assert property (@(posedge clk) disable iff (rst)
      req[dll_pkg::SRC_ACK_HI] |-> !gnt[dll_pkg::SRC_NEW]) else $error("new tlp beat nak");
   chk_replay_beats_new: assert property (@(posedge clk) disable iff (rst)
      replay_q |-> !tl_tx_ready) else $error("new tlp taken during replay");
   chk_seq_advance: assert property (@(posedge clk) disable iff (rst)
      (fire && gnt[dll_pkg::SRC_NEW]) |=> next_seq_q == $past(next_seq_q) + 12'h001) else $error("seq not advanced");
   chk_tx_seq_out: assert property (@(posedge clk) disable iff (rst)
      (fire && gnt[dll_pkg::SRC_NEW]) |=> ph_tx_valid && !ph_tx_is_dllp && ph_tx_tlp.seq == $past(next_seq_q)) else $error("bad tx seq");
   chk_lcrc_out: assert property (@(posedge clk) disable iff (rst)
      (ph_tx_valid && !ph_tx_is_dllp) |-> ph_tx_crc == lcrc(ph_tx_tlp)) else $error("bad lcrc");
   chk_nak_replay: assert property (@(posedge clk) disable iff (rst)
      (nak_ok && !replay_q && in_flight != 12'h000) |=> replay_q) else $error("nak gave no replay");
   chk_timer_replay: assert property (@(posedge clk) disable iff (rst)
      (tmr_q >= dll_pkg::REPLAY_CYC && !replay_q && in_flight != 12'h000) |=> replay_q) else $error("timeout gave no replay");
   chk_bad_crc_nak: assert property (@(posedge clk) disable iff (rst)
      (ph_rx_tlp_valid && !rx_crc_ok && !nak_sched_q) |=> nak_pend_q) else $error("no nak on bad crc");
   chk_good_rx_ack: assert property (@(posedge clk) disable iff (rst)
      (ph_rx_tlp_valid && rx_crc_ok && ph_rx_tlp.seq == rx_seq_q) |=> tl_rx_valid && ack_pend_q) else $error("no ack");
   chk_link_up: assert property (@(posedge clk) disable iff (rst)
      tl_link_up |-> $past(link_q) == LS_UP) else $error("bad link status");
   cov_replay: cover property (@(posedge clk) disable iff (rst) $rose(replay_q));
   cov_link_up: cover property (@(posedge clk) disable iff (rst) $rose(tl_link_up));
   cov_retrain: cover property (@(posedge clk) disable iff (rst) ph_retrain);
endmodule : dll_core
`default_nettype wire

// file: dll_pkg.sv
// package: shared constants and carrier types for the data link layer
package dll_pkg;
   localparam int SEQ_W = 12;
   localparam int DATA_W = 32;
   localparam int RB_AW = 4;
   localparam int RB_DEPTH = 16;
   localparam logic [15:0] DLLP_POLY = 16'h100b;
   localparam logic [15:0] DLLP_INIT = 16'hffff;
   localparam logic [31:0] LCRC_POLY = 32'h04c11db7;
   localparam logic [31:0] LCRC_INIT = 32'hffffffff;
   localparam logic [11:0] SEQ_RST = 12'h000;
   localparam logic [11:0] SEQ_HALF = 12'h800;
   localparam int REPLAY_NS = 1000;
   localparam int CLK_NS = 8;
   localparam logic [11:0] REPLAY_CYC = 12'((REPLAY_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] ERR_RETRAIN = 4'h4;
   localparam logic [7:0] DT_ACK = 8'h00;
   localparam logic [7:0] DT_NAK = 8'h10;
   localparam logic [7:0] DT_PM = 8'h20;
   localparam logic [7:0] DT_INITFC = 8'h40;
   localparam logic [7:0] DT_UPDFC = 8'h80;
   localparam int NREQ = 8;
   typedef enum logic [2:0] {
      SRC_INITFC, SRC_ACK_HI, SRC_UFC_HI, SRC_PM, SRC_REPLAY, SRC_NEW, SRC_UFC_LO, SRC_ACK_LO
   } src_e;
   typedef struct packed {
      logic [7:0] dtype;
      logic [23:0] body;
   } dllp_s;
   typedef struct packed {
      logic [11:0] seq;
      logic [31:0] data;
   } tlp_s;
   typedef struct packed {
      logic [7:0] hdr;
      logic [11:0] data;
   } credit_s;
endpackage : dll_pkg

// file: dll_arbiter.sv
// fixed priority transmit arbiter
`timescale 1ns/1ps
`default_nettype none
module dll_arbiter (
   // requests, bit 0 highest
   input wire logic [dll_pkg::NREQ-1:0] req,
   // one-hot grant
   output logic [dll_pkg::NREQ-1:0] gnt
);
   logic [dll_pkg::NREQ-1:0] seen;
   genvar i;
   assign seen[0] = 1'b0;
   generate
      for (i = 1; i < dll_pkg::NREQ; i++) begin : g_chain
         assign seen[i] = seen[i-1] | req[i-1];
      end
      for (i = 0; i < dll_pkg::NREQ; i++) begin : g_gnt
         assign gnt[i] = req[i] & ~seen[i];
      end
   endgenerate
endmodule : dll_arbiter
`default_nettype wire

// file: phy_model.sv
// partner model: physical layer facing the link layer core
`timescale 1ns/1ps
`default_nettype none
module phy_model (
   // clock
   input wire logic clk,
   // transmit from the core
   input wire logic ph_tx_valid,
   input wire logic ph_tx_is_dllp,
   input wire dll_pkg::tlp_s ph_tx_tlp,
   input wire logic [31:0] ph_tx_crc,
   input wire dll_pkg::dllp_s ph_tx_dllp,
   output logic ph_tx_ready,
   // receive toward the core
   output logic ph_rx_tlp_valid,
   output dll_pkg::tlp_s ph_rx_tlp,
   output logic [31:0] ph_rx_tlp_crc,
   output logic ph_rx_dllp_valid,
   output dll_pkg::dllp_s ph_rx_dllp,
   output logic [15:0] ph_rx_dllp_crc
);
   logic slow = 1'b0;
   logic [1:0] tick = 2'h0;
   logic [108:0] seen[$];
   initial begin
      ph_tx_ready = 1'b0;
      ph_rx_tlp_valid = 1'b0;
      ph_rx_tlp = '0;
      ph_rx_tlp_crc = '0;
      ph_rx_dllp_valid = 1'b0;
      ph_rx_dllp = '0;
      ph_rx_dllp_crc = '0;
   end
   // slow mode takes one word in four, as a lane busy with skip sets would
   always @(posedge clk) begin
      tick <= tick + 2'h1;
      ph_tx_ready <= !slow || tick == 2'h2;
      if (ph_tx_valid && ph_tx_ready) begin
         seen.push_back({ph_tx_is_dllp, ph_tx_tlp, ph_tx_crc, ph_tx_dllp});
      end
   end
   // released lines carry the inverse, so stale values never look fresh
   task automatic send_dllp(input logic [31:0] d, input logic [15:0] c);
      ph_rx_dllp <= d;
      ph_rx_dllp_crc <= c;
      ph_rx_dllp_valid <= 1'b1;
      @(posedge clk);
      ph_rx_dllp <= ~d;
      ph_rx_dllp_crc <= ~c;
      ph_rx_dllp_valid <= 1'b0;
      @(posedge clk);
   endtask : send_dllp
   task automatic send_tlp(input logic [43:0] t, input logic [31:0] c);
      ph_rx_tlp <= t;
      ph_rx_tlp_crc <= c;
      ph_rx_tlp_valid <= 1'b1;
      @(posedge clk);
      ph_rx_tlp <= ~t;
      ph_rx_tlp_crc <= ~c;
      ph_rx_tlp_valid <= 1'b0;
      @(posedge clk);
   endtask : send_tlp
endmodule : phy_model
`default_nettype wire

// file: pcie_data_link_layer_test.sv
// testbench for the link layer core and its transmit arbiter
`timescale 1ns/1ps
`default_nettype none
module pcie_data_link_layer_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic tl_tx_valid = 1'b0;
   logic [31:0] tl_tx_data = 32'h0;
   logic tl_tx_ready, tl_rx_valid, tl_link_up, ph_tx_valid, ph_tx_is_dllp, ph_tx_ready;
   logic [31:0] tl_rx_data, ph_tx_crc, ph_rx_tlp_crc;
   dll_pkg::credit_s tl_credit_adv = 20'h0abcd;
   logic tl_credit_upd = 1'b0;
   dll_pkg::credit_s tl_credit_peer;
   dll_pkg::tlp_s ph_tx_tlp, ph_rx_tlp;
   dll_pkg::dllp_s ph_tx_dllp, ph_rx_dllp;
   logic ph_rx_tlp_valid, ph_rx_dllp_valid, ph_retrain, pm_low_power_req;
   logic [15:0] ph_rx_dllp_crc;
   logic ph_link_trained = 1'b0;
   int err_count = 0;
   int compares = 0;
   int cyc = 0;
   int rx_cnt = 0;
   int rt_cnt = 0;
   logic [31:0] rx_last = 32'h0;
   logic pm_seen = 1'b0;
   always #4 clk = ~clk;
   dll_core i_dut (.clk(clk), .rst(rst), .tl_tx_valid(tl_tx_valid), .tl_tx_data(tl_tx_data),
      .tl_tx_ready(tl_tx_ready), .tl_rx_valid(tl_rx_valid), .tl_rx_data(tl_rx_data),
      .tl_credit_adv(tl_credit_adv), .tl_credit_upd(tl_credit_upd), .tl_credit_peer(tl_credit_peer),
      .tl_link_up(tl_link_up), .ph_tx_valid(ph_tx_valid), .ph_tx_is_dllp(ph_tx_is_dllp),
      .ph_tx_tlp(ph_tx_tlp), .ph_tx_crc(ph_tx_crc), .ph_tx_dllp(ph_tx_dllp), .ph_tx_ready(ph_tx_ready),
      .ph_rx_tlp_valid(ph_rx_tlp_valid), .ph_rx_tlp(ph_rx_tlp), .ph_rx_tlp_crc(ph_rx_tlp_crc),
      .ph_rx_dllp_valid(ph_rx_dllp_valid), .ph_rx_dllp(ph_rx_dllp), .ph_rx_dllp_crc(ph_rx_dllp_crc),
      .ph_link_trained(ph_link_trained), .ph_retrain(ph_retrain), .pm_low_power_req(pm_low_power_req));
   phy_model i_phy (.clk(clk), .ph_tx_valid(ph_tx_valid), .ph_tx_is_dllp(ph_tx_is_dllp),
      .ph_tx_tlp(ph_tx_tlp), .ph_tx_crc(ph_tx_crc), .ph_tx_dllp(ph_tx_dllp), .ph_tx_ready(ph_tx_ready),
      .ph_rx_tlp_valid(ph_rx_tlp_valid), .ph_rx_tlp(ph_rx_tlp), .ph_rx_tlp_crc(ph_rx_tlp_crc),
      .ph_rx_dllp_valid(ph_rx_dllp_valid), .ph_rx_dllp(ph_rx_dllp), .ph_rx_dllp_crc(ph_rx_dllp_crc));
   // init doubles as width mask: bit 31 set means the 32-bit code
   function automatic logic [31:0] crc(input logic [63:0] v, input int nb, input logic [31:0] poly,
      input logic [31:0] init);
      logic [31:0] c;
      logic fb;
      c = init;
      for (int i = nb - 1; i >= 0; i--) begin
         fb = (init[31] ? c[31] : c[15]) ^ v[i];
         c = (c << 1) & init;
         if (fb) c = c ^ poly;
      end
      return ~c & init;
   endfunction : crc
   function automatic logic [31:0] lc(input logic [43:0] t);
      return crc({20'h0, t}, 44, dll_pkg::LCRC_POLY, dll_pkg::LCRC_INIT);
   endfunction : lc
   function automatic logic [15:0] dc(input logic [31:0] d);
      return 16'(crc({32'h0, d}, 32, {16'h0, dll_pkg::DLLP_POLY}, {16'h0, dll_pkg::DLLP_INIT}));
   endfunction : dc
   task automatic give_verdict();
      $display("compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : give_verdict
   // the whole run needs some 400 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (tl_rx_valid === 1'b1) begin
         rx_cnt <= rx_cnt + 1;
         rx_last <= tl_rx_data;
      end
      if (ph_retrain === 1'b1) rt_cnt <= rt_cnt + 1;
      if (pm_low_power_req !== 1'b0) pm_seen <= 1'b1;
      if (cyc == 6000) begin
         err_count++;
         give_verdict();
      end
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         err_count++;
      end
   endtask : chk
   task automatic get_tx(output logic [108:0] v);
      v = '1;
      for (int n = 0; n < 400 && i_phy.seen.size() == 0; n++) @(posedge clk);
      if (i_phy.seen.size() == 0) chk(64'h0, 64'h1);
      else v = i_phy.seen.pop_front();
   endtask : get_tx
   task automatic exp_tlp(input logic [11:0] s, input logic [31:0] d);
      logic [108:0] v;
      get_tx(v);
      chk(v[108], 1'b0);
      chk(v[107:64], {s, d});
      chk(v[63:32], lc({s, d}));
   endtask : exp_tlp
   task automatic exp_dllp(input logic [7:0] ty, input logic [23:0] b, input logic [23:0] m);
      logic [108:0] v;
      get_tx(v);
      chk(v[108], 1'b1);
      chk(v[31:24], ty);
      chk(v[23:0] & m, b);
      chk(v[63:32], {16'h0, dc(v[31:0])});
   endtask : exp_dllp
   task automatic rx_dllp(input logic [7:0] ty, input logic [23:0] b);
      i_phy.send_dllp({ty, b}, dc({ty, b}));
   endtask : rx_dllp
   task automatic tl_send(input logic [31:0] d, input logic last);
      int n;
      n = 0;
      tl_tx_valid <= 1'b1;
      tl_tx_data <= d;
      // ready is combinational: judge it settled, before the edge that takes the word
      do begin
         @(negedge clk);
         n++;
      end while (tl_tx_ready !== 1'b1 && n < 400);
      @(posedge clk);
      if (last) tl_tx_valid <= 1'b0;
   endtask : tl_send
   task automatic t_link();
      ph_link_trained <= 1'b1;
      // peer init is only heard once our own init has gone out
      exp_dllp(dll_pkg::DT_INITFC, 24'h0a0bcd, 24'h0fffff);
      rx_dllp(dll_pkg::DT_INITFC, 24'h012345);
      for (int n = 0; n < 60 && tl_link_up !== 1'b1; n++) @(posedge clk);
      chk(tl_link_up, 1'b1);
      chk(tl_credit_peer, 20'h01345);
   endtask : t_link
   task automatic t_nak();
      tl_send(32'hcafe0001, 1'b0);
      tl_send(32'hcafe0002, 1'b1);
      exp_tlp(12'h000, 32'hcafe0001);
      exp_tlp(12'h001, 32'hcafe0002);
      rx_dllp(dll_pkg::DT_NAK, 24'h000000);
      exp_tlp(12'h001, 32'hcafe0002);
      rx_dllp(dll_pkg::DT_ACK, 24'h000001);
      repeat (200) @(posedge clk);
      chk(i_phy.seen.size(), 0);
   endtask : t_nak
   task automatic t_timer();
      i_phy.slow <= 1'b1;
      tl_send(32'h5eed0003, 1'b1);
      exp_tlp(12'h002, 32'h5eed0003);
      exp_tlp(12'h002, 32'h5eed0003);
      i_phy.slow <= 1'b0;
      rx_dllp(dll_pkg::DT_ACK, 24'h000002);
   endtask : t_timer
   task automatic t_rx();
      i_phy.send_tlp({12'h000, 32'h0dd0beef}, lc({12'h000, 32'h0dd0beef}));
      exp_dllp(dll_pkg::DT_ACK, 24'h000000, 24'h000fff);
      chk(rx_last, 32'h0dd0beef);
      i_phy.send_tlp({12'h001, 32'h0bad0001}, ~lc({12'h001, 32'h0bad0001}));
      exp_dllp(dll_pkg::DT_NAK, 24'h000000, 24'h000fff);
      chk(rx_cnt, 1);
      i_phy.send_tlp({12'h001, 32'h600d0001}, lc({12'h001, 32'h600d0001}));
      exp_dllp(dll_pkg::DT_ACK, 24'h000001, 24'h000fff);
      chk(rx_cnt, 2);
   endtask : t_rx
   task automatic t_retrain();
      // the bad tlp in t_rx already counted one error, so three more trip it
      for (int i = 0; i < 3; i++) begin
         chk(rt_cnt, 0);
         i_phy.send_dllp(32'h00000007, ~dc(32'h00000007));
      end
      repeat (8) @(posedge clk);
      chk(rt_cnt, 1);
      i_phy.send_dllp(32'h00000007, ~dc(32'h00000007));
      repeat (8) @(posedge clk);
      chk(rt_cnt, 1);
   endtask : t_retrain
   task automatic t_arb();
      tl_credit_upd <= 1'b1;
      @(posedge clk);
      tl_tx_valid <= 1'b1;
      tl_tx_data <= 32'hab1e0004;
      @(posedge clk);
      tl_credit_upd <= 1'b0;
      @(posedge clk);
      tl_tx_valid <= 1'b0;
      exp_dllp(dll_pkg::DT_UPDFC, 24'h0a0bcd, 24'hffffff);
      exp_tlp(12'h003, 32'hab1e0004);
      exp_dllp(dll_pkg::DT_UPDFC, 24'h0a0bcd, 24'hffffff);
      rx_dllp(dll_pkg::DT_ACK, 24'h000003);
   endtask : t_arb
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_link();
      t_nak();
      t_timer();
      t_arb();
      t_rx();
      t_retrain();
      chk(pm_seen, 1'b0);
      give_verdict();
   end
endmodule : pcie_data_link_layer_test
`default_nettype wire
